/* File: src/sadc_pkg.sv */
package sadc_pkg;
   // ****************************************************************
   // frame geometry
   // ****************************************************************
   localparam int RES_BITS = 14;
   localparam int FRAME_CLKS = 18;
   localparam int LEAD_ZEROS = 2;
   localparam int LAST_BIT_EDGE = 16;
   localparam int CNT_W = 5;
   localparam logic [CNT_W-1:0] CNT_RST = 5'h00;
   localparam logic [CNT_W-1:0] LEAD_EDGES = 5'h02;
   localparam logic [CNT_W-1:0] ACQ_EDGE = 5'h10;
   localparam logic [RES_BITS-1:0] POS_FULL = 14'h1fff;
   localparam logic [RES_BITS-1:0] NEG_FULL = 14'h2000;

   // ****************************************************************
   // types
   // ****************************************************************
   typedef enum logic [2:0] {
      SADC_TRACK = 3'b001,
      SADC_CONV = 3'b010,
      SADC_ACQ = 3'b100
   } sadc_state_t;

   typedef struct packed {
      logic cs_n;
      logic sclk;
   } sadc_link_in_t;

   typedef struct packed {
      logic dout;
      logic dout_oe;
   } sadc_link_out_t;
endpackage : sadc_pkg

/* File: src/sadc_core.sv */
// Summary of operation
// (R1) frame spans 18 serial clocks
// (R2) host may raise select early
// (R3) result shifted out msb first
// (R4) bits belong to current frame's conversion
// (R5) track state after sixteenth falling edge
// (R6) input captured at start, held during conversion
// (R7) serial clock shifts and converts
// (R8) saturate high to positive full scale
// (R9) saturate low to negative full scale
// (R10) each conversion yields 14-bit word
// (R11) three wires: select, clock, data out
// (R12) two zeros, then 14 bits on edges 3-16
// (R13) data driven only while select low
// (R14) early select rise aborts conversion
// (R15) select fall with clock low counts as edge
// (R16) host samples on rising edge, signed
module sadc_core
   import sadc_pkg::*;
#(
   parameter int IN_W = 16
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic srst,
   // serial link pins
   input wire sadc_pkg::sadc_link_in_t link_in,
   output sadc_pkg::sadc_link_out_t link_out,
   // analog stand-in: signed differential input, wider than result
   input wire logic signed [IN_W-1:0] ain_diff,
   // status
   output logic tracking,
   output logic [RES_BITS-1:0] last_result
);
   import sadc_pkg::*;

   // ****************************************************************
   // pin synchronisers
   // ****************************************************************
   logic [1:0] cs_meta, sclk_meta;
   logic cs_s, sclk_s, cs_d, sclk_d;
   logic [1:0] next_cs_meta, next_sclk_meta;
   logic next_cs_d, next_sclk_d;

   always_comb begin
      next_cs_meta = {cs_meta[0], link_in.cs_n};
      next_sclk_meta = {sclk_meta[0], link_in.sclk};
      next_cs_d = cs_meta[1];
      next_sclk_d = sclk_meta[1];
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         cs_meta <= 2'h3;
         sclk_meta <= 2'h0;
         cs_d <= 1'b1;
         sclk_d <= 1'b0;
      end else begin
         cs_meta <= next_cs_meta;
         sclk_meta <= next_sclk_meta;
         cs_d <= next_cs_d;
         sclk_d <= next_sclk_d;
      end
   end

   assign cs_s = cs_meta[1];
   assign sclk_s = sclk_meta[1];

   logic cs_fall, cs_rise, sclk_fall;
   assign cs_fall = cs_d & ~cs_s;
   assign cs_rise = ~cs_d & cs_s;
   assign sclk_fall = sclk_d & ~sclk_s;

   // ****************************************************************
   // saturating quantiser
   // ****************************************************************
   function automatic logic [RES_BITS-1:0] sadc_quant(
      input logic signed [IN_W-1:0] v);
      logic signed [IN_W-1:0] hi, lo;
      // sign-extend the full-scale codes to the input width
      hi = IN_W'($signed(POS_FULL));
      lo = IN_W'($signed(NEG_FULL));
      if (v >= hi) sadc_quant = POS_FULL; // R8
      else if (v <= lo) sadc_quant = NEG_FULL; // R9
      else sadc_quant = v[RES_BITS-1:0]; // R10
   endfunction : sadc_quant

   // ****************************************************************
   // frame sequencer
   // ****************************************************************
   sadc_state_t state, next_state;
   logic [CNT_W-1:0] edge_cnt, next_edge_cnt;
   logic [RES_BITS-1:0] sample, next_sample;
   logic [RES_BITS-1:0] result, next_result;
   logic dout, next_dout;
   logic first_edge, any_edge;

   // select falling with clock low is itself the first edge
   assign first_edge = cs_fall & ~sclk_s; // R15
   assign any_edge = (~cs_s & sclk_fall) | first_edge; // R7

   always_comb begin
      next_state = state;
      next_edge_cnt = edge_cnt;
      next_sample = sample;
      next_result = result;
      next_dout = dout;
      unique case (state)
         SADC_TRACK: begin
            next_dout = 1'b0;
            if (cs_fall) begin
               next_state = SADC_CONV;
               next_sample = sadc_quant(ain_diff); // R6 R4
               next_edge_cnt = first_edge ? 5'h01 : CNT_RST;
            end
         end
         SADC_CONV: begin
            if (cs_rise) begin
               next_state = SADC_TRACK; // R14 R2
               next_dout = 1'b0;
            end else if (any_edge) begin
               next_edge_cnt = edge_cnt + 5'h01;
               // lead zeros then msb-first bits
               if (edge_cnt < LEAD_EDGES) begin
                  next_dout = 1'b0; // R12
               end else begin
                  next_dout = sample[RES_BITS-1-(edge_cnt-LEAD_EDGES)]; // R3
               end
               if (edge_cnt + 5'h01 == ACQ_EDGE) begin
                  next_state = SADC_ACQ; // R5
                  next_result = sample;
               end
            end
         end
         SADC_ACQ: begin
            // lsb stays on the pin until select rises
            if (cs_rise) begin
               next_state = SADC_TRACK; // R1
               next_dout = 1'b0;
            end
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         state <= SADC_TRACK;
         edge_cnt <= CNT_RST;
         sample <= '0;
         result <= '0;
         dout <= 1'b0;
      end else begin
         state <= next_state;
         edge_cnt <= next_edge_cnt;
         sample <= next_sample;
         result <= next_result;
         dout <= next_dout;
      end
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   // one driver for the whole struct keeps strict tools quiet
   assign link_out = '{dout: dout, dout_oe: ~cs_s}; // R11 R13
   assign tracking = (state != SADC_CONV); // R5
   assign last_result = result;

   // ****************************************************************
   // checks
   // ****************************************************************
   AST_OE_FOLLOWS_CS: // R13
      assert property (@(posedge ref_clk) disable iff (srst)
         (!$past(srst) && !$past(srst, 2))
         |-> link_out.dout_oe == !$past(link_in.cs_n, 2))
      else $error("output enable not tied to select");
   AST_LEAD_ZERO: // R12
      assert property (@(posedge ref_clk) disable iff (srst)
         (state == SADC_CONV && edge_cnt <= LEAD_EDGES) |-> !dout)
      else $error("leading zero not driven");
   AST_ABORT: // R14
      assert property (@(posedge ref_clk) disable iff (srst)
         (state == SADC_CONV && cs_rise) |=> state == SADC_TRACK)
      else $error("early select rise did not abort");
   AST_TRACK_AT_16: // R5
      assert property (@(posedge ref_clk) disable iff (srst)
         (state == SADC_CONV && any_edge && !cs_rise
          && edge_cnt == 5'h0f) |=> state == SADC_ACQ && tracking)
      else $error("no track state after sixteenth edge");
   AST_MSB_ON_THIRD: // R3
      assert property (@(posedge ref_clk) disable iff (srst)
         (state == SADC_CONV && any_edge && !cs_rise
          && edge_cnt == LEAD_EDGES) |=> dout == sample[RES_BITS-1])
      else $error("msb not on third edge");
   AST_SAMPLE_HELD: // R6
      assert property (@(posedge ref_clk) disable iff (srst)
         (state == SADC_CONV && $past(state) == SADC_CONV)
         |-> $stable(sample))
      else $error("sample changed during conversion");
   AST_START: // R4
      assert property (@(posedge ref_clk) disable iff (srst)
         (state == SADC_TRACK && cs_fall)
         |=> state == SADC_CONV && sample == sadc_quant($past(ain_diff)))
      else $error("conversion not started on select fall");
   AST_FIRST_EDGE: // R15
      assert property (@(posedge ref_clk) disable iff (srst)
         (state == SADC_TRACK && cs_fall && !sclk_s) |=> edge_cnt == 5'h01)
      else $error("select fall with clock low not counted");
   AST_RESULT_KEPT: // R10
      assert property (@(posedge ref_clk) disable iff (srst)
         state == SADC_ACQ |-> last_result == sample)
      else $error("result not kept");

   COV_FULL_FRAME:
      cover property (@(posedge ref_clk) disable iff (srst)
         state == SADC_ACQ ##1 state == SADC_TRACK);
   COV_SHORT:
      cover property (@(posedge ref_clk) disable iff (srst)
         state == SADC_CONV && cs_rise && edge_cnt > 5'h04);
   COV_POS_SAT:
      cover property (@(posedge ref_clk) disable iff (srst)
         state == SADC_CONV && sample == POS_FULL);
   COV_NEG_SAT:
      cover property (@(posedge ref_clk) disable iff (srst)
         state == SADC_CONV && sample == NEG_FULL);
endmodule : sadc_core

/* File: dv/sadc_host.sv */
module sadc_host
   import sadc_pkg::*;
(
   // clock
   input wire logic ref_clk,
   // link pins
   output sadc_pkg::sadc_link_in_t link_in,
   input wire sadc_pkg::sadc_link_out_t link_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic wire_d;
   logic lead_seen;
   // released line flips, never a stale bit
   assign wire_d = link_out.dout_oe ? link_out.dout : ~link_out.dout;
   initial link_in = 2'h3;
   task automatic half();
      repeat (8) @(posedge ref_clk);
   endtask : half
   // nper 18 is a full frame; fewer than 16 short-cycle it
   task automatic frame(input int nper, input bit low,
                        output logic [RES_BITS-1:0] w);
      w = '0;
      lead_seen = 1'b0;
      if (low) begin
         link_in.sclk <= 1'b0;
         half();
      end
      link_in.cs_n <= 1'b0;
      if (!low) half();
      for (int k = 1; k <= nper; k++) begin
         if (!(low && k == 1)) link_in.sclk <= 1'b0;
         half();
         link_in.sclk <= 1'b1;
         if (k <= LEAD_ZEROS) lead_seen = lead_seen | wire_d;
         if (k > LEAD_ZEROS && k <= LAST_BIT_EDGE)
            w = {w[RES_BITS-2:0], wire_d};
         half();
      end
      link_in.cs_n <= 1'b1;
      half();
   endtask : frame
endmodule : sadc_host

/* File: dv/serial_adc_conversion_readout_bench.sv */
module serial_adc_conversion_readout_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import sadc_pkg::*;
   typedef struct packed {
      logic signed [15:0] ain;
      logic [RES_BITS-1:0] res;
   } sadc_row_t;
   logic ref_clk = 1'b0;
   logic srst = 1'b1;
   logic signed [15:0] ain_diff = 16'sh0000;
   sadc_link_in_t link_in;
   sadc_link_out_t link_out;
   logic tracking;
   logic [RES_BITS-1:0] last_result;
   logic [RES_BITS-1:0] w;
   int err_count = 0;
   int num_checks = 0;
   int cycles = 0;
   sadc_row_t rows [12] = '{
      '{16'sh0000, 14'h0000}, '{16'sh0001, 14'h0001},
      '{16'shfffb, 14'h3ffb}, '{16'sh1555, 14'h1555},
      '{16'sh1ffe, 14'h1ffe}, '{16'sh1fff, 14'h1fff},
      '{16'sh2328, 14'h1fff}, '{16'sh7fff, 14'h1fff},
      '{16'she001, 14'h2001}, '{16'she000, 14'h2000},
      '{16'shdcd8, 14'h2000}, '{16'sh8000, 14'h2000}};
   always #5 ref_clk = ~ref_clk;
   // ****************************************
   // design and host
   // ****************************************
   sadc_core #(.IN_W(16)) sadc_core_i (
      .ref_clk(ref_clk), .srst(srst), .link_in(link_in),
      .link_out(link_out), .ain_diff(ain_diff), .tracking(tracking),
      .last_result(last_result));
   sadc_host sadc_host_i (
      .ref_clk(ref_clk), .link_in(link_in), .link_out(link_out));
   // ****************************************
   // checking and closing
   // ****************************************
   task automatic check(input string name,
                        input logic [RES_BITS-1:0] seen, exp);
      num_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : end_of_test
   // whole run is near 4100 cycles
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles >= 20000) begin
         err_count++;
         end_of_test();
      end
   end
   initial begin
      repeat (5) @(posedge ref_clk);
      srst <= 1'b0;
      repeat (3) @(posedge ref_clk);
      check("oe", 14'(link_out.dout_oe), 14'h0);
      check("trk", 14'(tracking), 14'h1);
      check("last", last_result, 14'h0);
      $display("reset test done");
      // odd rows start with the serial clock low
      foreach (rows[i]) begin
         ain_diff <= rows[i].ain;
         sadc_host_i.frame(18, i[0], w);
         check("word", w, rows[i].res);
         check("lead", 14'(sadc_host_i.lead_seen), 14'h0);
         check("last", last_result, rows[i].res);
         check("trk", 14'(tracking), 14'h1);
         check("oe", 14'(link_out.dout_oe), 14'h0);
      end
      $display("table test done");
      ain_diff <= 16'sh0123;
      sadc_host_i.frame(8, 1'b0, w);
      check("short word", w, 14'h0001);
      check("abort last", last_result, 14'h2000);
      check("abort oe", 14'(link_out.dout_oe), 14'h0);
      $display("abort test done");
      ain_diff <= 16'sh0777;
      fork
         sadc_host_i.frame(18, 1'b1, w);
         begin
            repeat (40) @(posedge ref_clk);
            ain_diff <= 16'sh0042;
            check("busy trk", 14'(tracking), 14'h0);
            check("busy oe", 14'(link_out.dout_oe), 14'h1);
            repeat (240) @(posedge ref_clk);
            check("held trk", 14'(tracking), 14'h1);
            check("held last", last_result, 14'h0777);
         end
      join
      check("fresh word", w, 14'h0777);
      $display("hold test done");
      end_of_test();
   end
endmodule : serial_adc_conversion_readout_bench
